// ===== pkg/fdf_link_if.sv
`timescale 1ns/1ps

interface fdf_link_if;
    import fdf_pkg::*;

    logic                  serialWriteClock;
    logic                  writePointerReset;
    logic                  writeAdvanceEnable;
    logic                  writeMaskEnable;
    logic [FDF_DATA_W-1:0] inputDataWord;
    logic                  serialReadClock;
    logic                  readPointerReset;
    logic                  readAdvanceEnable;
    logic                  outputEnable;
    logic [FDF_DATA_W-1:0] outputDataWord;
    logic                  outputDataWordOeN;

    modport device_mp (
        input  serialWriteClock,
        input  writePointerReset,
        input  writeAdvanceEnable,
        input  writeMaskEnable,
        input  inputDataWord,
        input  serialReadClock,
        input  readPointerReset,
        input  readAdvanceEnable,
        input  outputEnable,
        output outputDataWord,
        output outputDataWordOeN
    );

    modport ctrl_mp (
        output serialWriteClock,
        output writePointerReset,
        output writeAdvanceEnable,
        output writeMaskEnable,
        output inputDataWord,
        output serialReadClock,
        output readPointerReset,
        output readAdvanceEnable,
        output outputEnable,
        input  outputDataWord,
        input  outputDataWordOeN
    );

endinterface : fdf_link_if

// ===== pkg/fdf_pkg.sv
package fdf_pkg;

    // Storage geometry
    localparam int              FDF_DATA_W        = 12;
    localparam int              FDF_ADDR_W        = 19;
    localparam int              FDF_DEPTH         = 262214;
    localparam logic [18:0]     FDF_ADDR_LAST     = 19'h4_0045;
    localparam logic [18:0]     FDF_FIELD_MAX     = 19'h4_0046;
    localparam int              FDF_LINE_DEPTH    = 256;
    localparam int              FDF_LINE_ADDR_W   = 8;

    // Controller sequencing counts
    localparam logic [7:0]      FDF_MIN_ACTIVE    = 8'h96;
    localparam logic [6:0]      FDF_DUMMY_LAST    = 7'h4F;
    localparam logic [1:0]      FDF_RESET_LOW_MIN = 2'h2;

    // Serial clock made by the controller: four mclk per period
    localparam logic [1:0]      FDF_PHASE_LAST    = 2'h3;

    // Internal refresh slot, one mclk in every 64
    localparam logic [5:0]      FDF_REFRESH_LAST  = 6'h3F;

    localparam logic [11:0]     FDF_WORD_ZERO     = 12'h000;
    localparam logic [18:0]     FDF_ADDR_ZERO     = 19'h0_0000;

    typedef enum logic [1:0] {
        FDF_ST_DUMMY = 2'b00,
        FDF_ST_RESET = 2'b01,
        FDF_ST_RUN   = 2'b11
    } fdf_ctrl_state_t;

endpackage : fdf_pkg

// ===== rtl/fdf_field_controller.sv
`timescale 1ns/1ps

module fdf_field_controller
    import fdf_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rst,
    fdf_link_if.ctrl_mp                link,
    input  wire logic [FDF_DATA_W-1:0] inputWord,
    input  wire logic                  inputValid,
    input  wire logic                  inputMask,
    input  wire logic                  fieldEnd,
    input  wire logic                  readEnable,
    input  wire logic                  readRestart,
    output logic                       inputReady,
    output logic [FDF_DATA_W-1:0]      readWord,
    output logic                       readValid,
    output logic                       initDone
);

    fdf_ctrl_state_t       state_reg;
    fdf_ctrl_state_t       state_next;
    logic [1:0]            phase_reg;
    logic [1:0]            phase_next;
    logic [6:0]            dummyCnt_reg;
    logic [6:0]            dummyCnt_next;
    logic [7:0]            activeCnt_reg;
    logic [7:0]            activeCnt_next;
    logic [18:0]           fieldCnt_reg;
    logic [18:0]           fieldCnt_next;
    logic [1:0]            wLow_reg;
    logic [1:0]            wLow_next;
    logic [1:0]            rLow_reg;
    logic [1:0]            rLow_next;
    logic                  sclk_reg;
    logic                  sclk_next;
    logic                  wRst_reg;
    logic                  wRst_next;
    logic                  wAdv_reg;
    logic                  wAdv_next;
    logic                  wMask_reg;
    logic                  wMask_next;
    logic [FDF_DATA_W-1:0] wData_reg;
    logic [FDF_DATA_W-1:0] wData_next;
    logic                  rRst_reg;
    logic                  rRst_next;
    logic                  rAdv_reg;
    logic                  rAdv_next;
    logic                  oe_reg;
    logic                  oe_next;
    logic                  ready_reg;
    logic                  ready_next;
    logic [FDF_DATA_W-1:0] rWord_reg;
    logic [FDF_DATA_W-1:0] rWord_next;
    logic                  rValid_reg;
    logic                  rValid_next;
    logic                  slot;
    logic                  endField;

    assign link.serialWriteClock   = sclk_reg;
    assign link.serialReadClock    = sclk_reg;
    assign link.writePointerReset  = wRst_reg;
    assign link.writeAdvanceEnable = wAdv_reg;
    assign link.writeMaskEnable    = wMask_reg;
    assign link.inputDataWord      = wData_reg;
    assign link.readPointerReset   = rRst_reg;
    assign link.readAdvanceEnable  = rAdv_reg;
    assign link.outputEnable       = oe_reg;
    assign inputReady              = ready_reg;
    assign readWord                = rWord_reg;
    assign readValid               = rValid_reg;
    // Run is the only state with bit 1 set
    assign initDone                = state_reg[1];

    always_comb
    begin
        phase_next     = phase_reg + 2'h1;
        slot           = (phase_reg == FDF_PHASE_LAST);
        sclk_next      = phase_next[1];
        state_next     = state_reg;
        dummyCnt_next  = dummyCnt_reg;
        activeCnt_next = activeCnt_reg;
        fieldCnt_next  = fieldCnt_reg;
        wLow_next      = wLow_reg;
        rLow_next      = rLow_reg;
        wRst_next      = wRst_reg;
        wAdv_next      = wAdv_reg;
        wMask_next     = wMask_reg;
        wData_next     = wData_reg;
        rRst_next      = rRst_reg;
        rAdv_next      = rAdv_reg;
        oe_next        = oe_reg;
        ready_next     = 1'b0;
        rWord_next     = rWord_reg;
        rValid_next    = 1'b0;
        endField       = 1'b0;
        if (slot)
        begin
            if (rAdv_reg && !link.outputDataWordOeN)
            begin
                rWord_next  = link.outputDataWord;
                rValid_next = 1'b1;
            end
            wLow_next = (wRst_reg || wLow_reg == FDF_RESET_LOW_MIN) ? wLow_reg : wLow_reg + 2'h1;
            rLow_next = (rRst_reg || rLow_reg == FDF_RESET_LOW_MIN) ? rLow_reg : rLow_reg + 2'h1;
            if (wRst_reg)
            begin
                wLow_next = 2'h0;
            end
            if (rRst_reg)
            begin
                rLow_next = 2'h0;
            end
            case (state_reg)
                FDF_ST_DUMMY:
                begin
                    dummyCnt_next = dummyCnt_reg + 7'h01;
                    if (dummyCnt_reg == FDF_DUMMY_LAST)
                    begin
                        state_next = FDF_ST_RESET;
                    end
                end
                FDF_ST_RESET:
                begin
                    wRst_next      = 1'b1;
                    rRst_next      = 1'b1;
                    activeCnt_next = 8'h00;
                    fieldCnt_next  = FDF_ADDR_ZERO;
                    oe_next        = 1'b1;
                    state_next     = FDF_ST_RUN;
                end
                FDF_ST_RUN:
                begin
                    endField = (fieldEnd && activeCnt_reg == FDF_MIN_ACTIVE)
                        || (fieldCnt_reg == FDF_FIELD_MAX);
                    if (endField && !wRst_reg && wLow_next == FDF_RESET_LOW_MIN)
                    begin
                        wRst_next      = 1'b1;
                        wAdv_next      = 1'b0;
                        activeCnt_next = 8'h00;
                        fieldCnt_next  = FDF_ADDR_ZERO;
                    end
                    else
                    begin
                        wRst_next  = 1'b0;
                        wAdv_next  = inputValid && (fieldCnt_reg != FDF_FIELD_MAX);
                        wMask_next = inputMask;
                        wData_next = inputWord;
                        ready_next = wAdv_next;
                        if (wAdv_next)
                        begin
                            fieldCnt_next = fieldCnt_reg + 19'h0_0001;
                            if (activeCnt_reg != FDF_MIN_ACTIVE)
                            begin
                                activeCnt_next = activeCnt_reg + 8'h01;
                            end
                        end
                    end
                    rRst_next = readRestart && !rRst_reg && rLow_next == FDF_RESET_LOW_MIN;
                    rAdv_next = readEnable && !rRst_next;
                end
                default:
                begin
                    state_next = FDF_ST_DUMMY;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_reg     <= FDF_ST_DUMMY;
            phase_reg     <= 2'h0;
            dummyCnt_reg  <= 7'h00;
            activeCnt_reg <= 8'h00;
            fieldCnt_reg  <= FDF_ADDR_ZERO;
            wLow_reg      <= 2'h0;
            rLow_reg      <= 2'h0;
            sclk_reg      <= 1'b0;
            wRst_reg      <= 1'b0;
            wAdv_reg      <= 1'b0;
            wMask_reg     <= 1'b0;
            wData_reg     <= FDF_WORD_ZERO;
            rRst_reg      <= 1'b0;
            rAdv_reg      <= 1'b0;
            oe_reg        <= 1'b0;
            ready_reg     <= 1'b0;
            rWord_reg     <= FDF_WORD_ZERO;
            rValid_reg    <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            phase_reg     <= phase_next;
            dummyCnt_reg  <= dummyCnt_next;
            activeCnt_reg <= activeCnt_next;
            fieldCnt_reg  <= fieldCnt_next;
            wLow_reg      <= wLow_next;
            rLow_reg      <= rLow_next;
            sclk_reg      <= sclk_next;
            wRst_reg      <= wRst_next;
            wAdv_reg      <= wAdv_next;
            wMask_reg     <= wMask_next;
            wData_reg     <= wData_next;
            rRst_reg      <= rRst_next;
            rAdv_reg      <= rAdv_next;
            oe_reg        <= oe_next;
            ready_reg     <= ready_next;
            rWord_reg     <= rWord_next;
            rValid_reg    <= rValid_next;
        end
    end

endmodule : fdf_field_controller

// ===== rtl/fdf_field_memory.sv
`timescale 1ns/1ps

module fdf_field_memory
    import fdf_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          rst,
    fdf_link_if.device_mp      link,
    output logic               writeFieldFull
);

    logic [FDF_DATA_W-1:0] fieldArray [0:FDF_DEPTH-1];
    logic [FDF_DATA_W-1:0] lineBuf    [0:FDF_LINE_DEPTH-1];

    logic                  wclkPrev_reg;
    logic                  wclkPrev_next;
    logic [FDF_ADDR_W-1:0] wAddr_reg;
    logic [FDF_ADDR_W-1:0] wAddr_next;
    logic                  pendStore_reg;
    logic                  pendStore_next;
    logic [FDF_ADDR_W-1:0] pendAddr_reg;
    logic [FDF_ADDR_W-1:0] pendAddr_next;
    logic [FDF_DATA_W-1:0] pendData_reg;
    logic [FDF_DATA_W-1:0] pendData_next;
    logic                  cmtValid_reg;
    logic                  cmtValid_next;
    logic [FDF_ADDR_W-1:0] cmtAddr_reg;
    logic [FDF_ADDR_W-1:0] cmtAddr_next;
    logic [FDF_DATA_W-1:0] cmtData_reg;
    logic [FDF_DATA_W-1:0] cmtData_next;
    logic                  full_reg;
    logic                  full_next;

    logic                  rclkPrev_reg;
    logic                  rclkPrev_next;
    logic [FDF_ADDR_W-1:0] rAddr_reg;
    logic [FDF_ADDR_W-1:0] rAddr_next;
    logic [FDF_DATA_W-1:0] dataOut_reg;
    logic [FDF_DATA_W-1:0] dataOut_next;
    logic                  oeN_reg;
    logic                  oeN_next;

    logic [5:0]            refreshCnt_reg;
    logic [5:0]            refreshCnt_next;
    logic                  refreshSlot;
    logic                  cmtFire;
    logic                  wRise;
    logic                  rRise;
    logic                  rInLine;
    logic                  cmtInLine;

    assign writeFieldFull         = full_reg;
    assign link.outputDataWord    = dataOut_reg;
    assign link.outputDataWordOeN = oeN_reg;

    // Refresh timer; storage never needs an outside refresh
    always_comb
    begin
        refreshCnt_next = refreshCnt_reg + 6'h01;
        refreshSlot     = (refreshCnt_reg == FDF_REFRESH_LAST);
        cmtFire         = cmtValid_reg && !refreshSlot;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            refreshCnt_reg <= 6'h00;
        end
        else
        begin
            refreshCnt_reg <= refreshCnt_next;
        end
    end

    // Write port
    always_comb
    begin
        wRise          = link.serialWriteClock && !wclkPrev_reg;
        wclkPrev_next  = link.serialWriteClock;
        wAddr_next     = wAddr_reg;
        pendStore_next = pendStore_reg;
        pendAddr_next  = pendAddr_reg;
        pendData_next  = pendData_reg;
        cmtValid_next  = cmtValid_reg && !cmtFire;
        cmtAddr_next   = cmtAddr_reg;
        cmtData_next   = cmtData_reg;
        full_next      = full_reg;
        if (wRise)
        begin
            // Word from the previous edge reaches the array at the next edge with reset or advance high
            if (pendStore_reg && (link.writePointerReset || link.writeAdvanceEnable))
            begin
                cmtValid_next = 1'b1;
                cmtAddr_next  = pendAddr_reg;
                cmtData_next  = pendData_reg;
            end
            if (link.writePointerReset)
            begin
                wAddr_next     = FDF_ADDR_ZERO;
                pendStore_next = 1'b0;
                full_next      = 1'b0;
            end
            else if (link.writeAdvanceEnable)
            begin
                pendStore_next = link.writeMaskEnable;
                pendAddr_next  = wAddr_reg;
                pendData_next  = link.inputDataWord;
                if (wAddr_reg == FDF_ADDR_LAST)
                begin
                    wAddr_next = FDF_ADDR_ZERO;
                    full_next  = 1'b1;
                end
                else
                begin
                    wAddr_next = wAddr_reg + 19'h0_0001;
                end
            end
            // Advance low: nothing captured, pointer held
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wclkPrev_reg  <= 1'b0;
            wAddr_reg     <= FDF_ADDR_ZERO;
            pendStore_reg <= 1'b0;
            pendAddr_reg  <= FDF_ADDR_ZERO;
            pendData_reg  <= FDF_WORD_ZERO;
            cmtValid_reg  <= 1'b0;
            cmtAddr_reg   <= FDF_ADDR_ZERO;
            cmtData_reg   <= FDF_WORD_ZERO;
            full_reg      <= 1'b0;
        end
        else
        begin
            wclkPrev_reg  <= wclkPrev_next;
            wAddr_reg     <= wAddr_next;
            pendStore_reg <= pendStore_next;
            pendAddr_reg  <= pendAddr_next;
            pendData_reg  <= pendData_next;
            cmtValid_reg  <= cmtValid_next;
            cmtAddr_reg   <= cmtAddr_next;
            cmtData_reg   <= cmtData_next;
            full_reg      <= full_next;
        end
    end

    // Array and line buffer; the line buffer shadows the first 256 words
    assign cmtInLine = (cmtAddr_reg[FDF_ADDR_W-1:FDF_LINE_ADDR_W] == 11'h000);

    always_ff @(posedge mclk)
    begin
        if (cmtFire)
        begin
            fieldArray[cmtAddr_reg] <= cmtData_reg;
            if (cmtInLine)
            begin
                lineBuf[cmtAddr_reg[FDF_LINE_ADDR_W-1:0]] <= cmtData_reg;
            end
        end
    end

    // Read port, on its own serial clock
    always_comb
    begin
        rRise         = link.serialReadClock && !rclkPrev_reg;
        rclkPrev_next = link.serialReadClock;
        rInLine       = (rAddr_reg[FDF_ADDR_W-1:FDF_LINE_ADDR_W] == 11'h000);
        rAddr_next    = rAddr_reg;
        dataOut_next  = dataOut_reg;
        oeN_next      = oeN_reg;
        if (rRise)
        begin
            if (link.readPointerReset)
            begin
                rAddr_next = FDF_ADDR_ZERO;
            end
            else if (link.readAdvanceEnable)
            begin
                // First words come from the line buffer, no extra latency
                if (rInLine)
                begin
                    dataOut_next = lineBuf[rAddr_reg[FDF_LINE_ADDR_W-1:0]];
                end
                else
                begin
                    dataOut_next = fieldArray[rAddr_reg];
                end
                oeN_next = !link.outputEnable;
                if (rAddr_reg == FDF_ADDR_LAST)
                begin
                    rAddr_next = FDF_ADDR_ZERO;
                end
                else
                begin
                    rAddr_next = rAddr_reg + 19'h0_0001;
                end
            end
            else
            begin
                oeN_next = !link.outputEnable;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rclkPrev_reg <= 1'b0;
            rAddr_reg    <= FDF_ADDR_ZERO;
            dataOut_reg  <= FDF_WORD_ZERO;
            oeN_reg      <= 1'b1;
        end
        else
        begin
            rclkPrev_reg <= rclkPrev_next;
            rAddr_reg    <= rAddr_next;
            dataOut_reg  <= dataOut_next;
            oeN_reg      <= oeN_next;
        end
    end

endmodule : fdf_field_memory

// ===== sim/fdf_link_checker.sv
`timescale 1ns/1ps

module fdf_link_checker
    import fdf_pkg::*;
(
    input wire logic                  mclk,
    input wire logic                  rst,
    input wire logic                  serialWriteClock,
    input wire logic                  writePointerReset,
    input wire logic                  writeAdvanceEnable,
    input wire logic                  writeMaskEnable,
    input wire logic [FDF_DATA_W-1:0] inputDataWord,
    input wire logic                  serialReadClock,
    input wire logic                  readPointerReset,
    input wire logic                  readAdvanceEnable,
    input wire logic                  outputEnable,
    input wire logic [FDF_DATA_W-1:0] outputDataWord,
    input wire logic                  outputDataWordOeN
);
    logic [6:0] dummyRise;
    logic [7:0] activeRise;
    logic       fieldOn;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // Write rises since power-up and advancing rises since last write reset
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            dummyRise  <= 7'h00;
            activeRise <= 8'h00;
            fieldOn    <= 1'b0;
        end
        else if ($rose(serialWriteClock))
        begin
            if (dummyRise != 7'h50)
                dummyRise <= dummyRise + 7'h01;
            if (writePointerReset)
            begin
                activeRise <= 8'h00;
                fieldOn    <= 1'b1;
            end
            else if (writeAdvanceEnable && activeRise != 8'hFF)
                activeRise <= activeRise + 8'h01;
        end
    end

    a_clock_shape: assert property ($rose(serialWriteClock) |-> ##1 serialWriteClock ##1 !serialWriteClock)
        else $error("write clock high phase wrong");
    a_ctrl_stable: assert property (serialWriteClock |->
        $stable({writePointerReset, writeAdvanceEnable, writeMaskEnable, inputDataWord}))
        else $error("write pins moved while clock high");
    a_wrst_gap: assert property ($fell(writePointerReset) |-> !writePointerReset [*8])
        else $error("write reset low too briefly");
    a_rrst_gap: assert property ($fell(readPointerReset) |-> !readPointerReset [*8])
        else $error("read reset low too briefly");
    a_dummy_first: assert property ($rose(writePointerReset) |-> dummyRise == 7'h50)
        else $error("write reset before dummy clocks done");
    a_field_min: assert property ($rose(serialWriteClock) && writePointerReset && fieldOn
        |-> activeRise >= FDF_MIN_ACTIVE)
        else $error("field closed too early");
    a_oen_follow: assert property ($rose(serialReadClock) && !readPointerReset
        |=> outputDataWordOeN == !$past(outputEnable))
        else $error("output enable not followed");
    a_out_timing: assert property ($changed(outputDataWord) |-> serialReadClock)
        else $error("read data moved off a read edge");
    a_oen_timing: assert property ($changed(outputDataWordOeN) |-> serialReadClock)
        else $error("output drive moved off a read edge");
    a_rd_stable: assert property (serialReadClock |->
        $stable({readPointerReset, readAdvanceEnable, outputEnable}))
        else $error("read pins moved while clock high");
endmodule : fdf_link_checker

// ===== sim/field_delay_fifo_write_port_tb_top.sv
`timescale 1ns/1ps

module field_delay_fifo_write_port_tb_top
    import fdf_pkg::*;
();
    logic                  mclk;
    logic                  rst;
    logic [FDF_DATA_W-1:0] inputWord;
    logic [FDF_DATA_W-1:0] readWord;
    logic                  inputValid;
    logic                  inputMask;
    logic                  fieldEnd;
    logic                  readEnable;
    logic                  readRestart;
    logic                  inputReady;
    logic                  readValid;
    logic                  initDone;
    logic                  writeFieldFull;
    int                    badCount;
    int                    checks;
    int                    n;
    int                    j;

    fdf_link_if link();

    fdf_field_memory fdf_field_memory_inst (.mclk(mclk), .rst(rst), .link(link), .writeFieldFull(writeFieldFull));
    fdf_field_controller fdf_field_controller_inst (.mclk(mclk), .rst(rst), .link(link),
        .inputWord(inputWord), .inputValid(inputValid), .inputMask(inputMask), .fieldEnd(fieldEnd),
        .readEnable(readEnable), .readRestart(readRestart), .inputReady(inputReady),
        .readWord(readWord), .readValid(readValid), .initDone(initDone));
    fdf_link_checker fdf_link_checker_inst (.mclk(mclk), .rst(rst),
        .serialWriteClock(link.serialWriteClock), .writePointerReset(link.writePointerReset),
        .writeAdvanceEnable(link.writeAdvanceEnable), .writeMaskEnable(link.writeMaskEnable),
        .inputDataWord(link.inputDataWord), .serialReadClock(link.serialReadClock),
        .readPointerReset(link.readPointerReset), .readAdvanceEnable(link.readAdvanceEnable),
        .outputEnable(link.outputEnable),
        .outputDataWord(link.outputDataWord), .outputDataWordOeN(link.outputDataWordOeN));

    function automatic logic [11:0] pat(input int i);
        return 12'(i * 37 + 5);
    endfunction : pat

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checks, badCount);
        if (badCount == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic check_val(input logic [11:0] seen, input logic [11:0] expect_v);
        checks++;
        if (seen !== expect_v)
        begin
            badCount++;
            $display("FAIL t=%0t seen=%h expected=%h", $time, seen, expect_v);
        end
    endtask : check_val

    // Offers one word and holds it until the controller takes it, giving up after 20 mclk
    task automatic write_word(input logic [11:0] w, input logic m);
        int k;
        inputWord  <= w;
        inputMask  <= m;
        inputValid <= 1'b1;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (inputReady !== 1'b1 && k < 20);
        check_val({11'h000, inputReady}, 12'h001);
    endtask : write_word

    task automatic close_field();
        inputValid <= 1'b0;
        fieldEnd   <= 1'b1;
        repeat (12) @(posedge mclk);
        fieldEnd <= 1'b0;
        repeat (12) @(posedge mclk);
    endtask : close_field

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        badCount++;
        test_done();
    end

    initial
    begin
        rst = 1'b1;
        inputWord = 12'h000;
        inputValid = 1'b0;
        inputMask = 1'b0;
        fieldEnd = 1'b0;
        readEnable = 1'b0;
        readRestart = 1'b0;
        badCount = 0;
        checks = 0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        for (n = 0; n < 1000 && initDone !== 1'b1; n++)
            @(posedge mclk);
        check_val({11'h000, initDone}, 12'h001);
        $display("test init done");
        for (int i = 0; i < 160; i++)
            write_word(pat(i), 1'b1);
        close_field();
        $display("test first field done");
        for (int i = 0; i < 160; i++)
        begin
            // Early close request must be refused
            if (i == 10)
                fieldEnd <= 1'b1;
            if (i == 13)
                fieldEnd <= 1'b0;
            if (i == 80)
            begin
                inputValid <= 1'b0;
                repeat (20) @(posedge mclk);
            end
            write_word(~pat(i), (i % 4) != 0);
        end
        close_field();
        $display("test masked field done");
        readRestart <= 1'b1;
        repeat (12) @(posedge mclk);
        readRestart <= 1'b0;
        readEnable  <= 1'b1;
        j = 0;
        for (n = 0; n < 900 && j < 160; n++)
        begin
            @(posedge mclk);
            if (readValid === 1'b1)
            begin
                check_val(readWord, (j % 4) == 0 ? pat(j) : ~pat(j));
                j++;
            end
        end
        readEnable <= 1'b0;
        check_val(12'(j), 12'h0A0);
        check_val({11'h000, writeFieldFull}, 12'h000);
        $display("test read back done");
        test_done();
    end
endmodule : field_delay_fifo_write_port_tb_top
